// >>> xer_exception_unit.v
// Functional notes
// - six exception classes, each in a privileged mode; both aborts share abort mode
// - accept internal and external exception requests
// - coincident event requests kept, interrupt levels re-sampled, taken in order
// - entry saves return address and status word
// - return restores status word and PC
// - flag-setting data op to PC returns
// - load multiple with PC and restore returns
// - 32-bit state executes only when condition field holds
// - compact state r0-r7 share storage
// - compact state reaches r13-r15, limited high
// - handler fetch from vector table at zero
// - fast interrupt mode banks r8-r14
// - status word flags, masks, state, mode
`include "xer_regs.vh"
module xer_exception_unit #(
	parameter DW = 32
) (
	CLK,
	RST,
	FAST_IN,
	IRQ_IN,
	DABORT_IN,
	PABORT_REQ,
	UNDEF_REQ,
	SWTRAP_REQ,
	RET_DP_REQ,
	RET_MULTI_REQ,
	RET_PC_IN,
	INSTR,
	INSTR_VALID,
	RET_ADDR,
	WR_EN,
	WR_IDX,
	WR_DATA,
	RD_IDX,
	COMPACT_IDX,
	COMPACT_HI,
	RD_DATA,
	COMPACT_DATA,
	CUR_STATUS,
	SAVED_STATUS,
	PC_OUT,
	PC_LOAD,
	TAKEN,
	COND_PASS,
	PENDING
);
	input wire CLK;
	input wire RST;
	input wire FAST_IN;
	input wire IRQ_IN;
	input wire DABORT_IN;
	input wire PABORT_REQ;
	input wire UNDEF_REQ;
	input wire SWTRAP_REQ;
	input wire RET_DP_REQ;
	input wire RET_MULTI_REQ;
	input wire [DW-1:0] RET_PC_IN;
	input wire [DW-1:0] INSTR;
	input wire INSTR_VALID;
	input wire [DW-1:0] RET_ADDR;
	input wire WR_EN;
	input wire [3:0] WR_IDX;
	input wire [DW-1:0] WR_DATA;
	input wire [3:0] RD_IDX;
	input wire [2:0] COMPACT_IDX;
	input wire [1:0] COMPACT_HI;
	output reg [DW-1:0] RD_DATA;
	output reg [DW-1:0] COMPACT_DATA;
	output reg [DW-1:0] CUR_STATUS;
	output reg [DW-1:0] SAVED_STATUS;
	output reg [DW-1:0] PC_OUT;
	output reg PC_LOAD;
	output reg [5:0] TAKEN;
	output reg COND_PASS;
	output reg [5:0] PENDING;

	// pending bit order: 0 dabort, 1 fast, 2 irq, 3 pabort, 4 und, 5 trap
	localparam P_FAST = 1;
	localparam P_IRQ = 2;

	// external pins synchronised; internal requests used directly
	reg [2:0] sync1_q;
	reg [2:0] sync2_q;
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {DABORT_IN, IRQ_IN, FAST_IN};
			sync2_q <= sync1_q;
		end
	end
	wire fast_s = sync2_q[0];
	wire irq_s = sync2_q[1];
	reg dabt_d1_q;
	wire dabt_rise = sync2_q[2] & ~dabt_d1_q;

	reg [DW-1:0] sr_q;
	reg [5:0] pend_q;
	reg [5:0] pend_d;
	reg [DW-1:0] pc_q;
	// physical storage: r0-r7 shared, user and fast r8 up to link, sp and link per mode
	reg [DW-1:0] low_q [0:7];
	reg [DW-1:0] usr_hi_q [8:14];
	reg [DW-1:0] fast_hi_q [8:14];
	reg [DW-1:0] sp_q [0:3];
	reg [DW-1:0] lr_q [0:3];
	reg [DW-1:0] saved_q [0:4];

	wire [4:0] mode = sr_q[`XER_SR_MODE_HI:0];
	wire in_fast = (mode == `XER_MODE_FAST);
	// bank index for svc/abt/und/irq/fast; 3'h7 means user/system
	function [2:0] bank;
		input [4:0] m;
		begin
			case (m)
			`XER_MODE_SVC: bank = 3'h0;
			`XER_MODE_ABT: bank = 3'h1;
			`XER_MODE_UND: bank = 3'h2;
			`XER_MODE_IRQ: bank = 3'h3;
			`XER_MODE_FAST: bank = 3'h4;
			default: bank = 3'h7;
			endcase
		end
	endfunction
	wire [2:0] cur_bank = bank(mode);

	function [DW-1:0] rd_reg;
		input [3:0] idx;
		begin
			if (idx == 4'hf)
				rd_reg = pc_q;
			else if (idx < 4'h8)
				rd_reg = low_q[idx[2:0]];
			else if (in_fast)
				rd_reg = fast_hi_q[idx];
			else if (idx >= 4'hd && cur_bank != 3'h7)
				rd_reg = (idx == 4'hd) ? sp_q[cur_bank[1:0]] : lr_q[cur_bank[1:0]];
			else
				rd_reg = usr_hi_q[idx];
		end
	endfunction

	// condition evaluation against current flags
	function cond_ok;
		input [3:0] c;
		input n, z, cf, v;
		begin
			case (c)
			4'h0: cond_ok = z;
			4'h1: cond_ok = ~z;
			4'h2: cond_ok = cf;
			4'h3: cond_ok = ~cf;
			4'h4: cond_ok = n;
			4'h5: cond_ok = ~n;
			4'h6: cond_ok = v;
			4'h7: cond_ok = ~v;
			4'h8: cond_ok = cf & ~z;
			4'h9: cond_ok = ~cf | z;
			4'ha: cond_ok = (n == v);
			4'hb: cond_ok = (n != v);
			4'hc: cond_ok = ~z & (n == v);
			4'hd: cond_ok = z | (n != v);
			4'he: cond_ok = 1'b1;
			default: cond_ok = 1'b0;
			endcase
		end
	endfunction
	// compact state always executes; condition applies in 32-bit state only
	wire cond_now = sr_q[`XER_SR_T] | cond_ok(INSTR[`XER_COND_HI:`XER_COND_LO],
		sr_q[`XER_SR_N], sr_q[`XER_SR_Z], sr_q[`XER_SR_C], sr_q[`XER_SR_V]);
	wire exec_ok = INSTR_VALID & cond_now;

	// masked view: interrupts gated by status disables, traps need a passing instruction
	wire [5:0] new_req = {SWTRAP_REQ & exec_ok, UNDEF_REQ & INSTR_VALID, PABORT_REQ,
		irq_s, fast_s, dabt_rise};
	wire [5:0] pend_all = pend_q | new_req;
	reg [5:0] eligible;
	always @* begin
		eligible = pend_all;
		eligible[P_FAST] = pend_all[P_FAST] & ~sr_q[`XER_SR_F];
		eligible[P_IRQ] = pend_all[P_IRQ] & ~sr_q[`XER_SR_I];
	end
	reg [5:0] grant;
	integer k;
	always @* begin
		grant = 6'h00;
		for (k = 5; k >= 0; k = k - 1)
			if (eligible[k])
				grant = 6'h01 << k;
	end
	// traps fall through to supervisor; one class is granted per cycle
	wire take = |grant;
	reg [4:0] tgt_mode;
	reg [DW-1:0] tgt_vec;
	always @* begin
		tgt_mode = `XER_MODE_SVC;
		tgt_vec = `XER_VEC_TRAP;
		case (grant)
		6'h01: begin
			tgt_mode = `XER_MODE_ABT;
			tgt_vec = `XER_VEC_DABT;
		end
		6'h02: begin
			tgt_mode = `XER_MODE_FAST;
			tgt_vec = `XER_VEC_FAST;
		end
		6'h04: begin
			tgt_mode = `XER_MODE_IRQ;
			tgt_vec = `XER_VEC_IRQ;
		end
		6'h08: begin
			tgt_mode = `XER_MODE_ABT;
			tgt_vec = `XER_VEC_PABT;
		end
		6'h10: begin
			tgt_mode = `XER_MODE_UND;
			tgt_vec = `XER_VEC_UND;
		end
		default: begin
			tgt_mode = `XER_MODE_SVC;
			tgt_vec = `XER_VEC_TRAP;
		end
		endcase
	end
	wire [2:0] tgt_bank = bank(tgt_mode);
	// return only from a privileged exception mode that owns a saved word
	wire do_ret = ~take & exec_ok & (RET_DP_REQ | RET_MULTI_REQ) &
		(cur_bank != 3'h7);
	// load multiple delivers the popped pc; data op returns through the link register
	wire [DW-1:0] ret_pc = RET_MULTI_REQ ? RET_PC_IN : rd_reg(4'he);

	// levels re-sample each cycle; an event beside its own grant stays (set wins)
	always @* begin
		pend_d = (pend_all & ~grant) | (pend_q & new_req);
		pend_d[P_FAST] = 1'b0;
		pend_d[P_IRQ] = 1'b0;
	end

	integer i;
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			sr_q <= `XER_SR_RST;
			pend_q <= 6'h00;
			pc_q <= `XER_VEC_BASE;
			dabt_d1_q <= 1'b0;
			for (i = 0; i < 8; i = i + 1)
				low_q[i] <= {DW{1'b0}};
			for (i = 8; i < 15; i = i + 1) begin
				usr_hi_q[i] <= {DW{1'b0}};
				fast_hi_q[i] <= {DW{1'b0}};
			end
			for (i = 0; i < 4; i = i + 1) begin
				sp_q[i] <= {DW{1'b0}};
				lr_q[i] <= {DW{1'b0}};
			end
			for (i = 0; i < 5; i = i + 1)
				saved_q[i] <= {DW{1'b0}};
		end else begin
			dabt_d1_q <= sync2_q[2];
			pend_q <= pend_d;
			if (WR_EN && WR_IDX != 4'hf) begin
				if (WR_IDX < 4'h8)
					low_q[WR_IDX[2:0]] <= WR_DATA;
				else if (in_fast)
					fast_hi_q[WR_IDX] <= WR_DATA;
				else if (WR_IDX == 4'hd && cur_bank != 3'h7)
					sp_q[cur_bank[1:0]] <= WR_DATA;
				else if (WR_IDX == 4'he && cur_bank != 3'h7)
					lr_q[cur_bank[1:0]] <= WR_DATA;
				else
					usr_hi_q[WR_IDX] <= WR_DATA;
			end
			if (take) begin
				if (tgt_bank == 3'h4) begin
					fast_hi_q[14] <= RET_ADDR;
					sr_q[`XER_SR_F] <= 1'b1;
				end else
					lr_q[tgt_bank[1:0]] <= RET_ADDR;
				saved_q[tgt_bank] <= sr_q;
				sr_q[`XER_SR_MODE_HI:0] <= tgt_mode;
				sr_q[`XER_SR_I] <= 1'b1;
				sr_q[`XER_SR_T] <= 1'b0;
				pc_q <= tgt_vec;
			end else if (do_ret) begin
				sr_q <= saved_q[cur_bank];
				pc_q <= ret_pc;
			end else if (WR_EN && WR_IDX == 4'hf)
				pc_q <= WR_DATA;
		end
	end

	// output stage registered so every top output leaves a flip-flop
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			RD_DATA <= {DW{1'b0}};
			COMPACT_DATA <= {DW{1'b0}};
			CUR_STATUS <= `XER_SR_RST;
			SAVED_STATUS <= {DW{1'b0}};
			PC_OUT <= `XER_VEC_BASE;
			PC_LOAD <= 1'b0;
			TAKEN <= 6'h00;
			COND_PASS <= 1'b0;
			PENDING <= 6'h00;
		end else begin
			RD_DATA <= rd_reg(RD_IDX);
			// compact view: 0 = low reg, 1 = sp, 2 = lr, 3 = pc
			case (COMPACT_HI)
			2'h1: COMPACT_DATA <= rd_reg(4'hd);
			2'h2: COMPACT_DATA <= rd_reg(4'he);
			2'h3: COMPACT_DATA <= pc_q;
			default: COMPACT_DATA <= low_q[COMPACT_IDX];
			endcase
			CUR_STATUS <= sr_q;
			SAVED_STATUS <= (cur_bank == 3'h7) ? {DW{1'b0}} : saved_q[cur_bank];
			// shown with the load pulse so a consumer can take both together
			PC_OUT <= take ? tgt_vec : (do_ret ? ret_pc : pc_q);
			PC_LOAD <= take | do_ret;
			TAKEN <= grant;
			COND_PASS <= exec_ok;
			PENDING <= pend_all;
		end
	end
endmodule

// >>> xer_exception_unit_asserts.sv
`include "xer_regs.vh"
module xer_exception_unit_chk (
	input wire CLK,
	input wire RST,
	input wire [5:0] TAKEN,
	input wire PC_LOAD,
	input wire [31:0] PC_OUT,
	input wire [31:0] CUR_STATUS,
	input wire [31:0] SAVED_STATUS
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	property p_one; TAKEN != 6'h0 |-> $onehot(TAKEN); endproperty
	a_one: assert property (p_one) else $error("two grants");
	property p_load; TAKEN != 6'h0 |-> PC_LOAD; endproperty
	a_load: assert property (p_load) else $error("grant without load");
	property p_vdab; TAKEN[0] |-> PC_OUT == `XER_VEC_DABT; endproperty
	a_vdab: assert property (p_vdab) else $error("abort vector");
	property p_vtrap; TAKEN[5] |-> PC_OUT == `XER_VEC_TRAP; endproperty
	a_vtrap: assert property (p_vtrap) else $error("trap vector");
	property p_msvc; TAKEN[5] |=> CUR_STATUS[4:0] == `XER_MODE_SVC; endproperty
	a_msvc: assert property (p_msvc) else $error("trap mode");
	property p_mund; TAKEN[4] |=> CUR_STATUS[4:0] == `XER_MODE_UND; endproperty
	a_mund: assert property (p_mund) else $error("undef mode");
	property p_mask; TAKEN != 6'h0 |=> CUR_STATUS[`XER_SR_I]; endproperty
	a_mask: assert property (p_mask) else $error("irq not masked");
	property p_save; TAKEN != 6'h0 |=> SAVED_STATUS == $past(CUR_STATUS); endproperty
	a_save: assert property (p_save) else $error("status not saved");
endmodule
bind xer_exception_unit xer_exception_unit_chk u_chk (.CLK(CLK), .RST(RST), .TAKEN(TAKEN),
	.PC_LOAD(PC_LOAD), .PC_OUT(PC_OUT), .CUR_STATUS(CUR_STATUS), .SAVED_STATUS(SAVED_STATUS));

// >>> xer_irq_model.sv
module xer_irq_model (
	input wire logic clk,
	input wire logic [1:0] req,
	input wire logic abort_req,
	output logic fast_line,
	output logic irq_line,
	output logic abort_line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] hold_q = 3'h0;
	// level lines stay up while the source wants service
	assign fast_line = req[1];
	assign irq_line = req[0];
	// stretched so the core's 2-flop sync cannot miss it
	always @(posedge clk) hold_q <= {hold_q[1:0], abort_req};
	assign abort_line = |hold_q;
endmodule

// >>> xer_regs.vh
`ifndef XER_REGS_VH
`define XER_REGS_VH
`define XER_MODE_USR 5'h10
`define XER_MODE_FAST 5'h11
`define XER_MODE_IRQ 5'h12
`define XER_MODE_SVC 5'h13
`define XER_MODE_ABT 5'h17
`define XER_MODE_UND 5'h1b
`define XER_MODE_SYS 5'h1f
`define XER_VEC_BASE 32'h00000000
`define XER_VEC_UND 32'h00000004
`define XER_VEC_TRAP 32'h00000008
`define XER_VEC_PABT 32'h0000000c
`define XER_VEC_DABT 32'h00000010
`define XER_VEC_IRQ 32'h00000018
`define XER_VEC_FAST 32'h0000001c
`define XER_SR_N 31
`define XER_SR_Z 30
`define XER_SR_C 29
`define XER_SR_V 28
`define XER_SR_I 7
`define XER_SR_F 6
`define XER_SR_T 5
`define XER_SR_MODE_HI 4
`define XER_SR_RST 32'h000000d3
`define XER_COND_HI 31
`define XER_COND_LO 28
`endif

// >>> xer_tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, pab = 0, und = 0, swt = 0, rdp = 0, rlm = 0, wen = 0, abq = 0;
	logic [31:0] rpc = 0, ins = 32'he0000000, radr = 0, wd = 0, st = 32'hd3;
	logic vld = 1;
	logic [3:0] widx = 0, ridx = 0;
	logic [2:0] tidx = 0;
	logic [1:0] thi = 0, req = 0;
	wire [31:0] rdd, tdd, cst, sst, pco;
	wire pcl, cp, fq, iq, dab;
	wire [5:0] tk, pnd;
	int errors = 0, checks_done = 0, cyc = 0;
	xer_irq_model u_xer_irq_model (.clk(clk), .req(req), .abort_req(abq), .fast_line(fq),
		.irq_line(iq), .abort_line(dab));
	xer_exception_unit u_xer_exception_unit (.CLK(clk), .RST(rst), .FAST_IN(fq), .IRQ_IN(iq),
		.DABORT_IN(dab), .PABORT_REQ(pab), .UNDEF_REQ(und), .SWTRAP_REQ(swt), .RET_DP_REQ(rdp),
		.RET_MULTI_REQ(rlm), .RET_PC_IN(rpc), .INSTR(ins), .INSTR_VALID(vld), .RET_ADDR(radr),
		.WR_EN(wen), .WR_IDX(widx), .WR_DATA(wd), .RD_IDX(ridx), .COMPACT_IDX(tidx),
		.COMPACT_HI(thi), .RD_DATA(rdd), .COMPACT_DATA(tdd), .CUR_STATUS(cst),
		.SAVED_STATUS(sst), .PC_OUT(pco), .PC_LOAD(pcl), .TAKEN(tk), .COND_PASS(cp),
		.PENDING(pnd));
	task automatic finish_test;
		if (errors == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_tk;
		for (int i = 0; i < 6; i++) begin
			tick();
			if (tk !== 6'h0) break;
		end
	endtask
	task automatic regs;
		wen = 1;
		widx = 3;
		wd = 32'h5a5a0003;
		tick();
		widx = 13;
		wd = 32'h5a5a000d;
		tick();
		wen = 0;
		tidx = 3;
		tick(2);
		chk(tdd, 32'h5a5a0003);
		thi = 1;
		tick(2);
		chk(tdd, 32'h5a5a000d);
	endtask
	task automatic cond_fail;
		ins = 32'h0;
		swt = 1;
		tick();
		swt = 0;
		ins = 32'he0000000;
		chk(cp, 0);
		chk(tk, 0);
		tick(2);
		chk(tk, 0);
		vld = 0;
		und = 1;
		tick();
		und = 0;
		vld = 1;
		chk(cp, 0);
		chk(pnd, 0);
	endtask
	task automatic masked;
		req = 2'h3;
		for (int i = 0; i < 10; i++) begin
			tick();
			chk(tk & 6'h6, 0);
		end
		chk(pnd, 6'h06);
		req = 0;
	endtask
	task automatic entry(input int k, input logic [31:0] vec, input logic [4:0] md);
		logic [31:0] old;
		old = st;
		st[7] = 1'b1;
		st[4:0] = md;
		radr = 32'h100 + k;
		{swt, und, pab} = 3'h1 << k;
		tick();
		{swt, und, pab} = 0;
		chk(tk, 6'h8 << k);
		chk(pco, vec);
		chk(cp, 1);
		ridx = 14;
		tick();
		chk(cst, st);
		chk(sst, old);
		tick();
		chk(rdd, radr);
	endtask
	task automatic prio;
		radr = 32'h300;
		{swt, und, pab} = 3'h7;
		tick();
		{swt, und, pab} = 0;
		chk(tk, 6'h08);
		chk(pnd, 6'h38);
		wait_tk();
		chk(tk, 6'h10);
		wait_tk();
		chk(tk, 6'h20);
		tick(2);
		rpc = 32'h2000;
		rlm = 1;
		tick();
		rlm = 0;
		chk(pco, 32'h2000);
		chk(pcl, 1);
		tick();
		chk(cst, 32'hdb);
		rdp = 1;
		tick();
		rdp = 0;
		chk(pco, 32'h300);
		tick();
		chk(cst, 32'hd7);
	endtask
	task automatic ext_abort;
		abq = 1;
		tick();
		abq = 0;
		wait_tk();
		chk(tk, 6'h1);
		chk(pco, 32'h10);
	endtask
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			finish_test();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		#1 rst = 0;
		tick(3);
		regs();
		cond_fail();
		masked();
		entry(0, 32'hc, 5'h17);
		entry(1, 32'h4, 5'h1b);
		entry(2, 32'h8, 5'h13);
		prio();
		ext_abort();
		finish_test();
	end
endmodule
